// ==== verilog/rpsc_pkg.sv ====
// package: constants and types of the row pointer and shutter control block
package rpsc_pkg;
  localparam int ROWS = 512;
  localparam int ROW_W = 9;
  localparam int PIX_W = 10;
  localparam int GAIN_W = 2;
  localparam int SHIFT_W = 4;
  // typical row blanking and pixel period, in ns, for the exposure readback
  localparam int ROW_BLANK_NS = 3200;
  localparam int PIX_PERIOD_NS = 125;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ROW_BLANK_CYC = ROW_BLANK_NS / CLK_PERIOD_NS;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_READ_START = 8'h04;
  localparam logic [7:0] ADDR_RESET_START = 8'h08;
  localparam logic [7:0] ADDR_READ_POS = 8'h0C;
  localparam logic [7:0] ADDR_RESET_POS = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // control register fields
  localparam int CTRL_GAIN_LSB = 0;
  localparam int CTRL_GAIN_SW = 2;
  localparam logic [ROW_W-1:0] START_RST = 9'h000;
  localparam logic [1:0] GAIN_RST = 2'h0;
  typedef enum logic [1:0] {
    RPSC_GAIN1 = 2'b00,
    RPSC_GAIN2 = 2'b01,
    RPSC_GAIN4 = 2'b10,
    RPSC_GAIN8 = 2'b11
  } rpsc_gain_e;
endpackage : rpsc_pkg

// ==== verilog/rpsc_row_pointer.sv ====
// one-hot row selection shift register with preset start row
`timescale 1ns/1ps
module rpsc_row_pointer #(
  parameter int ROWS = rpsc_pkg::ROWS,
  parameter int ROW_W = rpsc_pkg::ROW_W
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic rowClk,
  input wire logic rowSync,
  input wire logic [ROW_W-1:0] startRow,
  output logic [ROWS-1:0] rowSel,
  output logic [ROW_W-1:0] rowIdx
);
  import rpsc_pkg::*;
  typedef struct packed {
    logic [ROWS-1:0] sel;
    logic [ROW_W-1:0] idx;
  } rpsc_ptr_s;
  rpsc_ptr_s st_q;
  rpsc_ptr_s st_d;
  initial
  begin
    if (ROWS > (1 << ROW_W) || ROWS < 2)
      $error("rpsc_row_pointer: ROWS does not fit ROW_W");
  end
  always_comb
  begin
    st_d = st_q;
    if (rowSync)
    begin
      st_d.sel = '0;
      st_d.sel[startRow] = 1'b1;
      st_d.idx = startRow;
    end
    else if (rowClk)
    begin
      // pointer walks down by one row; past the last row it wraps to row 0
      st_d.sel = {st_q.sel[ROWS-2:0], st_q.sel[ROWS-1]};
      st_d.idx = (st_q.idx == ROW_W'(ROWS - 1)) ? '0 : st_q.idx + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_q.sel <= {{(ROWS-1){1'b0}}, 1'b1};
      st_q.idx <= '0;
    end
    else
      st_q <= st_d;
  end
  assign rowSel = st_q.sel;
  assign rowIdx = st_q.idx;
  AST_ONE_HOT: assert property (@(posedge clk) disable iff (!rstN) $onehot(rowSel))
    else $error("row pointer not one-hot");
  AST_IDX_MATCH: assert property (@(posedge clk) disable iff (!rstN) rowSel[rowIdx])
    else $error("row index and one-hot select disagree");
  AST_SYNC_LOAD: assert property (@(posedge clk) disable iff (!rstN)
    rowSync |=> rowSel[$past(startRow)] && rowIdx == $past(startRow))
    else $error("sync did not load start row");
  AST_STEP: assert property (@(posedge clk) disable iff (!rstN)
    (rowClk && !rowSync && rowIdx != ROW_W'(ROWS - 1)) |=> rowIdx == $past(rowIdx) + 1'b1)
    else $error("clock did not advance pointer by one row");
  AST_WRAP: assert property (@(posedge clk) disable iff (!rstN)
    (rowClk && !rowSync && rowIdx == ROW_W'(ROWS - 1)) |=> rowIdx == '0 && rowSel[0])
    else $error("pointer did not wrap to the first row");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rstN)
    (!rowClk && !rowSync) |=> $stable(rowSel))
    else $error("pointer moved without clock or sync");
endmodule : rpsc_row_pointer

// ==== verilog/rpsc_top.sv ====
// row pointer and electronic shutter control with APB registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - two one-hot row pointers, one row each
// - 512 positions per row pointer
// - clock pulse advances pointer one row down
// - sync pulse loads preset start row
// - read pointer reads, reset pointer resets rows
// - pointer row offset sets integration time
// - column amps sample signal and reset level
// - readout destroys charge, no accumulation
// - four gains from two gain select pins
// - preset start registers allow windowed readout
// - line reset drains charge, starts exposure
// - row values leave serially, one pixel each
// - gains are one, two, four, eight
module rpsc_top #(
  parameter int ROWS = rpsc_pkg::ROWS,
  parameter int ROW_W = rpsc_pkg::ROW_W,
  parameter int PIX_W = rpsc_pkg::PIX_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic readRowClk,
  input wire logic readRowSync,
  input wire logic resetRowClk,
  input wire logic resetRowSync,
  input wire logic gainSelectLow,
  input wire logic gainSelectHigh,
  input wire logic sampleLine,
  input wire logic pixelValid,
  input wire logic [PIX_W-1:0] pixelColumn [ROWS],
  input wire logic [ROW_W-1:0] pixelX,
  output logic [ROWS-1:0] readRowSel,
  output logic [ROWS-1:0] resetRowSel,
  output logic [ROWS-1:0] rowDrain,
  output logic [3:0] outGain,
  output logic [PIX_W-1:0] pixelOut,
  output logic pixelOutValid
);
  import rpsc_pkg::*;
  typedef struct packed {
    logic [ROW_W-1:0] readStart;
    logic [ROW_W-1:0] resetStart;
    logic gainOverride;
    logic [1:0] gainSw;
    logic [31:0] rdata;
    logic [PIX_W-1:0] pix;
    logic pixValid;
    logic [31:0] lineCount;
  } rpsc_top_s;
  rpsc_top_s st_q;
  rpsc_top_s st_d;
  logic rstN;
  logic [1:0] rstSync_q;
  logic [ROW_W-1:0] readIdx;
  logic [ROW_W-1:0] resetIdx;
  logic [ROW_W-1:0] rowOffset;
  logic [1:0] gainCode;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  initial
  begin
    if (ROWS != (1 << ROW_W))
      $error("rpsc_top: ROWS must equal 2**ROW_W");
    if (PIX_W > 16 || PIX_W < 1)
      $error("rpsc_top: PIX_W out of range");
  end
  // reset release through two flops; kept apart from the state word since it has its own reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];
  // read pointer and reset pointer
  rpsc_row_pointer #(.ROWS(ROWS), .ROW_W(ROW_W)) uReadPtr (
    .clk(clk),
    .rstN(rstN),
    .rowClk(readRowClk),
    .rowSync(readRowSync),
    .startRow(st_q.readStart),
    .rowSel(readRowSel),
    .rowIdx(readIdx)
  );
  rpsc_row_pointer #(.ROWS(ROWS), .ROW_W(ROW_W)) uResetPtr (
    .clk(clk),
    .rstN(rstN),
    .rowClk(resetRowClk),
    .rowSync(resetRowSync),
    .startRow(st_q.resetStart),
    .rowSel(resetRowSel),
    .rowIdx(resetIdx)
  );
  // drain strobe for the row under reset, and for the row just read: readout is destructive
  for (genvar r = 0; r < ROWS; r++)
  begin : gDrain
    assign rowDrain[r] = sampleLine && (resetRowSel[r] || readRowSel[r]);
  end
  // exposure in rows, modulo the array, as seen by software
  assign rowOffset = resetIdx - readIdx;
  assign gainCode = st_q.gainOverride ? st_q.gainSw : {gainSelectHigh, gainSelectLow};
  always_comb
  begin
    unique case (rpsc_gain_e'(gainCode))
      RPSC_GAIN1: outGain = 4'h1;
      RPSC_GAIN2: outGain = 4'h2;
      RPSC_GAIN4: outGain = 4'h4;
      RPSC_GAIN8: outGain = 4'h8;
    endcase
  end
  assign addrOk = (paddr == ADDR_CTRL) || (paddr == ADDR_READ_START) ||
                  (paddr == ADDR_RESET_START) || (paddr == ADDR_READ_POS) ||
                  (paddr == ADDR_RESET_POS) || (paddr == ADDR_OFFSET) ||
                  (paddr == ADDR_STATUS);
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign wrEn = psel && penable && pwrite && addrOk;
  assign rdEn = psel && !penable && !pwrite;
  assign prdata = st_q.rdata;
  always_comb
  begin
    st_d = st_q;
    if (wrEn)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          st_d.gainSw = pwdata[CTRL_GAIN_LSB +: 2];
          st_d.gainOverride = pwdata[CTRL_GAIN_SW];
        end
        ADDR_READ_START: st_d.readStart = pwdata[ROW_W-1:0];
        ADDR_RESET_START: st_d.resetStart = pwdata[ROW_W-1:0];
        default: st_d.lineCount = st_q.lineCount;
      endcase
    end
    // read data prepared in setup so it stands valid through the access cycle
    if (rdEn)
    begin
      unique case (paddr)
        ADDR_CTRL: st_d.rdata = {29'h0, st_q.gainOverride, st_q.gainSw};
        ADDR_READ_START: st_d.rdata = 32'(st_q.readStart);
        ADDR_RESET_START: st_d.rdata = 32'(st_q.resetStart);
        ADDR_READ_POS: st_d.rdata = 32'(readIdx);
        ADDR_RESET_POS: st_d.rdata = 32'(resetIdx);
        ADDR_OFFSET: st_d.rdata = 32'(rowOffset);
        ADDR_STATUS: st_d.rdata = st_q.lineCount;
        default: st_d.rdata = 32'h0;
      endcase
    end
    if (readRowSync)
      st_d.lineCount = 32'h0;
    else if (readRowClk)
      st_d.lineCount = st_q.lineCount + 32'h1;
    // serial pixel output: one column value per strobe
    st_d.pixValid = pixelValid;
    if (pixelValid)
      st_d.pix = pixelColumn[pixelX];
  end
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_q.readStart <= START_RST;
      st_q.resetStart <= START_RST;
      st_q.gainOverride <= 1'b0;
      st_q.gainSw <= GAIN_RST;
      st_q.rdata <= 32'h0;
      st_q.pix <= '0;
      st_q.pixValid <= 1'b0;
      st_q.lineCount <= 32'h0;
    end
    else
    begin
      st_q.readStart <= st_d.readStart;
      st_q.resetStart <= st_d.resetStart;
      st_q.gainOverride <= st_d.gainOverride;
      st_q.gainSw <= st_d.gainSw;
      st_q.rdata <= st_d.rdata;
      st_q.pix <= st_d.pix;
      st_q.pixValid <= st_d.pixValid;
      st_q.lineCount <= st_d.lineCount;
    end
  end
  assign pixelOut = st_q.pix;
  assign pixelOutValid = st_q.pixValid;
  AST_PIXEL_OUT: assert property (@(posedge clk) disable iff (!rstN)
    pixelValid |=> pixelOutValid && pixelOut == $past(pixelColumn[pixelX]))
    else $error("pixel not passed to serial output");
  AST_PIXEL_IDLE: assert property (@(posedge clk) disable iff (!rstN)
    !pixelValid |=> !pixelOutValid && $stable(pixelOut))
    else $error("serial output moved without a pixel strobe");
  // pins and override both map code n to gain two to the n
  AST_GAIN_PINS: assert property (@(posedge clk) disable iff (!rstN)
    !st_q.gainOverride |-> outGain == (4'h1 << {gainSelectHigh, gainSelectLow}))
    else $error("gain pins did not select the gain");
  AST_GAIN_SW: assert property (@(posedge clk) disable iff (!rstN)
    st_q.gainOverride |-> outGain == (4'h1 << st_q.gainSw))
    else $error("software gain not applied");
  AST_GAIN_ONEHOT: assert property (@(posedge clk) disable iff (!rstN) $onehot(outGain))
    else $error("gain not a power of two");
  AST_DRAIN_RESET_ROW: assert property (@(posedge clk) disable iff (!rstN)
    sampleLine |-> (rowDrain & resetRowSel) == resetRowSel)
    else $error("reset row not drained");
  AST_DRAIN_READ_ROW: assert property (@(posedge clk) disable iff (!rstN)
    sampleLine |-> (rowDrain & readRowSel) == readRowSel)
    else $error("read row not reset after sampling");
  AST_NO_DRAIN_IDLE: assert property (@(posedge clk) disable iff (!rstN)
    !sampleLine |-> rowDrain == '0)
    else $error("drain without line sample");
  AST_DRAIN_ROWS: assert property (@(posedge clk) disable iff (!rstN)
    sampleLine |-> $countones(rowDrain) >= 1 && $countones(rowDrain) <= 2)
    else $error("drain strobe hit rows beyond the two pointers");
  AST_OFFSET_KEPT: assert property (@(posedge clk) disable iff (!rstN)
    (readRowClk == resetRowClk && !readRowSync && !resetRowSync) |=> $stable(rowOffset))
    else $error("row offset drifted under common row clocks");
  AST_SYNC_OFFSET: assert property (@(posedge clk) disable iff (!rstN)
    (readRowSync && resetRowSync) |=>
      rowOffset == ROW_W'($past(st_q.resetStart) - $past(st_q.readStart)))
    else $error("synced pointers do not hold the preset offset");
  // bus checks: the zero-wait slave settles every transfer in its first access cycle
  AST_WRITE_CTRL: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && pwrite && paddr == ADDR_CTRL) |=> st_q.gainSw ==
      $past(pwdata[CTRL_GAIN_LSB +: 2]) && st_q.gainOverride == $past(pwdata[CTRL_GAIN_SW]))
    else $error("control write did not land");
  AST_WRITE_READ_START: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && pwrite && paddr == ADDR_READ_START) |=>
      st_q.readStart == $past(pwdata[ROW_W-1:0]))
    else $error("read start write did not land");
  AST_WRITE_RESET_START: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && pwrite && paddr == ADDR_RESET_START) |=>
      st_q.resetStart == $past(pwdata[ROW_W-1:0]))
    else $error("reset start write did not land");
  AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && pwrite && paddr != ADDR_CTRL && paddr != ADDR_READ_START &&
      paddr != ADDR_RESET_START) |=> $stable(st_q.readStart) && $stable(st_q.resetStart)
      && $stable(st_q.gainSw) && $stable(st_q.gainOverride))
    else $error("write to a read-only or unmapped word changed a register");
  AST_SLVERR: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable) |-> pready && (pslverr == !(paddr <= ADDR_STATUS && paddr[1:0] == 2'h0)))
    else $error("bus response wrong for the address");
  AST_READ_CTRL: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr == ADDR_CTRL) |->
      prdata == 32'({st_q.gainOverride, st_q.gainSw}))
    else $error("control readback wrong");
  AST_READ_STARTS: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && (paddr == ADDR_READ_START || paddr == ADDR_RESET_START))
      |-> prdata == 32'((paddr == ADDR_READ_START) ? st_q.readStart : st_q.resetStart))
    else $error("start row readback wrong");
  // position words are captured at setup, so they show the previous cycle's pointers
  AST_READ_POS: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr == ADDR_READ_POS) |->
      prdata == 32'($past(readIdx)))
    else $error("read pointer readback wrong");
  AST_READ_RESET_POS: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr == ADDR_RESET_POS) |->
      prdata == 32'($past(resetIdx)))
    else $error("reset pointer readback wrong");
  AST_READ_OFFSET: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr == ADDR_OFFSET) |->
      prdata == 32'(ROW_W'($past(resetIdx) - $past(readIdx))))
    else $error("offset readback wrong");
  AST_READ_STATUS: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr == ADDR_STATUS) |->
      prdata == $past(st_q.lineCount))
    else $error("line count readback wrong");
  AST_READ_UNMAPPED: assert property (@(posedge clk) disable iff (!rstN)
    (psel && penable && !pwrite && paddr > ADDR_STATUS) |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  AST_LINE_COUNT: assert property (@(posedge clk) disable iff (!rstN)
    (readRowClk && !readRowSync) |=> st_q.lineCount == $past(st_q.lineCount) + 32'h1)
    else $error("line count did not follow the read clock");
  AST_LINE_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
    readRowSync |=> st_q.lineCount == 32'h0)
    else $error("line count not cleared by read sync");
  sequence SEQ_START_WRITE;
    psel && penable && pwrite && paddr == ADDR_READ_START;
  endsequence
  // no other write may land before the sync samples the start register
  sequence SEQ_SYNC_AFTER;
    (!(psel && penable && pwrite))[*2] ##1 (readRowSync && !readRowClk);
  endsequence
  AST_START_THEN_SYNC: assert property (@(posedge clk) disable iff (!rstN)
    SEQ_START_WRITE ##1 SEQ_SYNC_AFTER |=> readIdx == $past(pwdata[ROW_W-1:0], 4))
    else $error("sync did not use programmed start row");
endmodule : rpsc_top

// ==== verif/rpsc_ctl_model.sv ====
// partner model: timing controller that pulses the row clocks and syncs
`timescale 1ns/1ps
module rpsc_ctl_model (
  input wire logic clk,
  input wire logic rstN,
  input wire logic lineGo,
  input wire logic syncReadGo,
  input wire logic syncResetGo,
  output logic readRowClk,
  output logic readRowSync,
  output logic resetRowClk,
  output logic resetRowSync
);
  // one line strobe drives both clocks, so the exposure offset cannot drift
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      readRowClk <= 1'b0;
      resetRowClk <= 1'b0;
      readRowSync <= 1'b0;
      resetRowSync <= 1'b0;
    end
    else
    begin
      readRowClk <= lineGo;
      resetRowClk <= lineGo;
      readRowSync <= syncReadGo;
      resetRowSync <= syncResetGo;
    end
  end
endmodule : rpsc_ctl_model

// ==== verif/tb_row_pointer_shutter_control.sv ====
// testbench: row pointers, shutter offset, gain and pixel path over APB
`timescale 1ns/1ps
module tb_row_pointer_shutter_control;
  import rpsc_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic gLow, gHigh, sampleLine, pixelValid, pixelOutValid, lineGo, syncRdGo, syncRsGo;
  logic rdClk, rdSync, rsClk, rsSync;
  logic [PIX_W-1:0] pixelColumn [ROWS];
  logic [ROW_W-1:0] pixelX;
  logic [ROWS-1:0] readRowSel, resetRowSel, rowDrain;
  logic [3:0] outGain;
  logic [PIX_W-1:0] pixelOut;
  // row: gain code {high,low}, column index, expected gain
  logic [14:0] rows [4] = '{{2'h0, 9'h000, 4'h1}, {2'h1, 9'h001, 4'h2},
    {2'h2, 9'h0FF, 4'h4}, {2'h3, 9'h1FF, 4'h8}};
  int failures = 0;
  int check_count = 0;
  // controller's line time in ns: blanking plus a full line of pixels
  int lineNs = ROW_BLANK_NS + PIX_PERIOD_NS * ROWS;
  rpsc_top uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .readRowClk(rdClk), .readRowSync(rdSync), .resetRowClk(rsClk),
    .resetRowSync(rsSync), .gainSelectLow(gLow), .gainSelectHigh(gHigh),
    .sampleLine(sampleLine), .pixelValid(pixelValid), .pixelColumn(pixelColumn),
    .pixelX(pixelX), .readRowSel(readRowSel), .resetRowSel(resetRowSel),
    .rowDrain(rowDrain), .outGain(outGain), .pixelOut(pixelOut),
    .pixelOutValid(pixelOutValid));
  rpsc_ctl_model ctl (.clk(clk), .rstN(resetn), .lineGo(lineGo), .syncReadGo(syncRdGo),
    .syncResetGo(syncRsGo), .readRowClk(rdClk), .readRowSync(rdSync),
    .resetRowClk(rsClk), .resetRowSync(rsSync));
  function automatic logic [ROWS-1:0] oh(input int n);
    return {{(ROWS-1){1'b0}}, 1'b1} << n;
  endfunction : oh
  task automatic chk(input string name, input logic [ROWS-1:0] exp, input logic [ROWS-1:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait states are the slave's call; only the watchdog ends a hung transfer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one-cycle command to the controller model, then time for the pointer to land
  task automatic cmd(input logic ln, input logic sr, input logic ss);
    @(posedge clk);
    lineGo <= ln;
    syncRdGo <= sr;
    syncRsGo <= ss;
    @(posedge clk);
    lineGo <= 1'b0;
    syncRdGo <= 1'b0;
    syncRsGo <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : cmd
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #25000;
    failures++;
    stop_test();
  end
  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata, gLow, gHigh} = '0;
    {sampleLine, pixelValid, pixelX, lineGo, syncRdGo, syncRsGo} = '0;
    for (int i = 0; i < ROWS; i++) pixelColumn[i] = 10'(i + 7);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("readRowSel", oh(0), readRowSel);
    chk("pixelOutValid", '0, ROWS'(pixelOutValid));
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      {gHigh, gLow} <= rows[r][14:13];
      pixelX <= rows[r][12:4];
      pixelValid <= 1'b1;
      @(posedge clk);
      pixelValid <= 1'b0;
      #1;
      chk("outGain", ROWS'(rows[r][3:0]), ROWS'(outGain));
      chk("pixelOut", ROWS'(rows[r][12:4] + 7), ROWS'(pixelOut));
      chk("pixelOutValid", ROWS'(1), ROWS'(pixelOutValid));
    end
    {gHigh, gLow} <= 2'h0;
    apb(1'b1, ADDR_CTRL, 32'h0000_0007);
    #1;
    chk("outGain", ROWS'(8), ROWS'(outGain));
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_READ_START, 32'h5);
    apb(1'b1, ADDR_RESET_START, 32'h9);
    apb(1'b0, ADDR_READ_START, 32'h0);
    chk("readStart", ROWS'(5), ROWS'(rdData));
    chk("slverr", '0, ROWS'(rdErr));
    cmd(1'b0, 1'b1, 1'b1);
    chk("readRowSel", oh(5), readRowSel);
    chk("resetRowSel", oh(9), resetRowSel);
    apb(1'b0, ADDR_OFFSET, 32'h0);
    chk("offset", ROWS'(4), ROWS'(rdData));
    chk("exposureNs", ROWS'(4 * lineNs), ROWS'(rdData * lineNs));
    repeat (3) cmd(1'b1, 1'b0, 1'b0);
    chk("readRowSel", oh(8), readRowSel);
    chk("resetRowSel", oh(12), resetRowSel);
    apb(1'b0, ADDR_READ_POS, 32'h0);
    chk("readPos", ROWS'(8), ROWS'(rdData));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("lines", ROWS'(3), ROWS'(rdData));
    @(posedge clk);
    sampleLine <= 1'b1;
    @(posedge clk);
    #1;
    chk("rowDrain", oh(8) | oh(12), rowDrain);
    sampleLine <= 1'b0;
    @(posedge clk);
    #1;
    chk("rowDrain", '0, rowDrain);
    apb(1'b1, ADDR_READ_START, 32'h1FF);
    cmd(1'b0, 1'b1, 1'b0);
    chk("readRowSel", oh(511), readRowSel);
    cmd(1'b1, 1'b0, 1'b0);
    chk("readRowSel", oh(0), readRowSel);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", ROWS'(1), ROWS'(rdErr));
    chk("prdata", '0, ROWS'(rdData));
    stop_test();
  end
endmodule : tb_row_pointer_shutter_control
